// >>> logic/apof_pkg.sv
// Package: constants for the parallel output formatter
package apof_pkg;
    localparam int RESULT_W = 12;
    localparam int TAG_W = 4;
    localparam int WORD_W = RESULT_W + TAG_W;
    localparam int STATUS_W = 7;
    localparam int UPPER_W = 3;
    localparam int LOWER_W = RESULT_W - UPPER_W;
    localparam int SYNC_STAGES = 2;
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [TAG_W-1:0] TAG_RST = 4'h0;
    localparam logic [RESULT_W-1:0] MSB_FLIP = 12'h800;
    localparam int CONV_NS = 1400;
    localparam int CLK_NS = 50;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 6;
    typedef enum logic [1:0] {
        APOF_IDLE = 2'b01,
        APOF_CONV = 2'b10
    } apof_state_t;
endpackage

// >>> logic/apof_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module apof_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] d, // Raw pin level
    output logic [W-1:0] q // Synchronised level
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> logic/apof_top.sv
// Parallel output formatter of an eight-channel converter
// Contract
// - Output word is 12-bit result plus tag: three address bits and diff flag.
// - Data pins drive only while read strobe and chip select are both low.
// - Result coding follows polarity_select level alone, no other format control.
// - Polarity_select low gives straight binary, step full scale over 4096.
// - Polarity_select high gives two's complement, step bipolar span over 4096.
// - Readback shows seven-bit sequencer entry while read strobe and chip select low, top three result pins and four tag pins used.
// - Readback keeps lower nine result pins undriven regardless of read strobe.
// - Busy output low from one edge after conversion entry, high once new result is ready.
`timescale 1ns/1ps
`default_nettype none
module apof_top
    import apof_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic ce, // Clock enable
    input wire logic rd_n, // Read strobe pin
    input wire logic cs_n, // Chip select pin
    input wire logic convst_n, // Conversion start pin
    input wire logic polarity_select, // Span polarity pin
    input wire logic readback_mode, // Sequencer readback active
    input wire logic [STATUS_W-1:0] sequencer_status_word, // Current sequencer entry
    input wire logic [2:0] chan_addr, // Channel of conversion
    input wire logic diff_mode, // Differential conversion
    input wire logic conv_done, // Converter core result ready pulse
    input wire logic [RESULT_W-1:0] raw_result, // Offset-binary core result
    output logic busy_n, // Conversion in progress, low
    output logic [WORD_W-1:0] data_out, // Output word
    output logic [WORD_W-1:0] data_oe // Per-pin output enable
);
    // ***************************
    // Pin synchronisation
    // ***************************
    logic [3:0] pins_s;
    logic rd_act;
    logic cs_act;
    logic convst_act;
    logic pol_s;
    // Strobes inverted so the reset value reads as idle
    apof_sync #(.W(4)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .d({~rd_n, ~cs_n, ~convst_n, polarity_select}),
        .q(pins_s)
    );
    assign {rd_act, cs_act, convst_act, pol_s} = pins_s;

    // ***************************
    // Conversion tracking
    // ***************************
    apof_state_t state_q;
    logic start;
    assign start = convst_act && cs_act;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= APOF_IDLE;
        end else if (ce) begin
            unique case (state_q)
                APOF_IDLE: begin
                    if (start) begin
                        state_q <= APOF_CONV;
                    end
                end
                APOF_CONV: begin
                    if (conv_done) begin
                        state_q <= APOF_IDLE;
                    end
                end
                default: begin
                    state_q <= APOF_IDLE;
                end
            endcase
        end
    end
    // Busy drops one edge after entering conversion
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_n <= 1'b1;
        end else if (ce) begin
            busy_n <= !(state_q == APOF_CONV && !conv_done);
        end
    end

    // ***************************
    // Result coding and latch
    // ***************************
    function automatic logic [RESULT_W-1:0] apof_code(input logic [RESULT_W-1:0] r, input logic bip);
        apof_code = bip ? (r ^ MSB_FLIP) : r;
    endfunction
    logic [RESULT_W-1:0] result_q;
    logic [TAG_W-1:0] tag_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result_q <= RESULT_RST;
            tag_q <= TAG_RST;
        end else if (ce && state_q == APOF_CONV && conv_done) begin
            result_q <= apof_code(raw_result, pol_s);
            tag_q <= {chan_addr, diff_mode};
        end
    end

    // ***************************
    // Output drive
    // ***************************
    logic drive;
    assign drive = rd_act && cs_act;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_out <= '0;
        end else if (ce) begin
            if (readback_mode) begin
                // Lower bits zeroed, their enables stay low
                data_out <= {sequencer_status_word[6:4], {LOWER_W{1'b0}}, sequencer_status_word[3:0]};
            end else begin
                data_out <= {result_q, tag_q};
            end
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_oe <= '0;
        end else if (ce) begin
            if (readback_mode) begin
                data_oe <= {{UPPER_W{drive}}, {LOWER_W{1'b0}}, {TAG_W{drive}}};
            end else begin
                data_oe <= {WORD_W{drive}};
            end
        end
    end

    // ***************************
    // Checks
    // ***************************
    a_oe_needs_strobe: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !drive |=> data_oe == '0) else $error("Pins driven without read and select");

    a_oe_full_read: assert property (@(posedge clk_sys) disable iff (rst)
        ce && drive && !readback_mode |=> data_oe == {WORD_W{1'b1}})
        else $error("Normal read leaves pins undriven");

    a_word_normal: assert property (@(posedge clk_sys) disable iff (rst)
        ce && !readback_mode |=> data_out == $past({result_q, tag_q}))
        else $error("Output word is not result and tag");

    a_lower_float: assert property (@(posedge clk_sys) disable iff (rst)
        ce && readback_mode |=> data_oe[TAG_W +: LOWER_W] == '0) else $error("Lower pins driven in readback");

    a_lower_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        ce && readback_mode |=> data_out[TAG_W +: LOWER_W] == '0)
        else $error("Lower bits carry data in readback");

    a_status_map: assert property (@(posedge clk_sys) disable iff (rst)
        ce && readback_mode |=> data_out[3:0] == $past(sequencer_status_word[3:0])
        && data_out[15:13] == $past(sequencer_status_word[6:4])) else $error("Status word misplaced");

    a_read_drive: assert property (@(posedge clk_sys) disable iff (rst)
        ce && drive && readback_mode |=> data_oe[15:13] == 3'h7) else $error("Status not driven");

    a_tag_drive: assert property (@(posedge clk_sys) disable iff (rst)
        ce && drive && readback_mode |=> data_oe[TAG_W-1:0] == {TAG_W{1'b1}})
        else $error("Status tag pins not driven");

    a_ce_freeze: assert property (@(posedge clk_sys) disable iff (rst)
        !ce |=> $stable(state_q) && $stable(busy_n) && $stable(data_oe) && $stable(data_out))
        else $error("State moved while clock enable low");

    // ***************************
    // Conversion checks
    // ***************************
    a_busy_conv: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_CONV && !conv_done |=> !busy_n) else $error("Busy high in conversion");

    a_busy_idle: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_IDLE |=> busy_n) else $error("Busy low while idle");

    a_busy_rise: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_CONV && conv_done |=> busy_n)
        else $error("Busy not released at result");

    a_start_conv: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_IDLE && start |=> state_q == APOF_CONV)
        else $error("Start not taken while idle");

    a_conv_hold: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_CONV && !conv_done |=> state_q == APOF_CONV)
        else $error("Conversion left without result");

    a_idle_no_done: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_IDLE && conv_done && !start |=> state_q == APOF_IDLE)
        else $error("Result pulse while idle not ignored");

    // ***************************
    // Coding checks
    // ***************************
    a_code_bip: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_CONV && conv_done && pol_s |=> result_q == ($past(raw_result) ^ MSB_FLIP))
        else $error("Bipolar coding wrong");

    a_code_uni: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_CONV && conv_done && !pol_s |=> result_q == $past(raw_result))
        else $error("Unipolar coding wrong");

    a_word_tag: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_CONV && conv_done |=> tag_q == $past({chan_addr, diff_mode}))
        else $error("Tag not captured");

    a_done_idle: assert property (@(posedge clk_sys) disable iff (rst)
        ce && state_q == APOF_IDLE |=> $stable(result_q) && $stable(tag_q))
        else $error("Held word changed while idle");

    // ***************************
    // Coverage
    // ***************************
    // Conversion, normal read, readback, bipolar result, freeze
    c_conv: cover property (@(posedge clk_sys) disable iff (rst) state_q == APOF_CONV ##1 busy_n);
    c_read: cover property (@(posedge clk_sys) disable iff (rst) drive && !readback_mode);
    c_rdbk: cover property (@(posedge clk_sys) disable iff (rst) drive && readback_mode);
    c_bip: cover property (@(posedge clk_sys) disable iff (rst) state_q == APOF_CONV && conv_done && pol_s);
    c_freeze: cover property (@(posedge clk_sys) disable iff (rst) !ce ##1 ce);
endmodule
`default_nettype wire

// >>> dv/apof_host.sv
// Host model driving strobes and reading the output bus
`timescale 1ns/1ps
`default_nettype none
module apof_host
    import apof_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic [WORD_W-1:0] data_out, // Device data
    input wire logic [WORD_W-1:0] data_oe, // Device enables
    output logic rd_n, // Read strobe
    output logic cs_n, // Chip select
    output logic convst_n // Conversion start
);
    logic [WORD_W-1:0] bus = '0;
    initial begin
        rd_n = 1'b1;
        cs_n = 1'b1;
        convst_n = 1'b1;
    end
    // Undriven bus bits toggle every cycle
    always @(posedge clk_sys) begin
        for (int i = 0; i < WORD_W; i++) begin
            bus[i] <= data_oe[i] ? data_out[i] : ~bus[i];
        end
    end
    task automatic start();
        @(negedge clk_sys);
        cs_n = 1'b0;
        convst_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        convst_n = 1'b1;
        cs_n = 1'b1;
    endtask
    task automatic rd_word(input logic sel_n, output logic [WORD_W-1:0] w, output logic [WORD_W-1:0] oe);
        @(negedge clk_sys);
        rd_n = 1'b0;
        cs_n = sel_n;
        repeat (5) @(negedge clk_sys);
        w = bus;
        oe = data_oe;
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> dv/apof_tb_top.sv
// Self-checking bench for the output formatter
`timescale 1ns/1ps
`default_nettype none
module apof_tb_top;
    import apof_pkg::*;
    logic clk_sys = 0, rst = 1, ce = 1, polarity_select = 0, readback_mode = 0, diff_mode = 0, conv_done = 0;
    logic [STATUS_W-1:0] sequencer_status_word = '0;
    logic [2:0] chan_addr = '0;
    logic [RESULT_W-1:0] raw_result = '0;
    logic rd_n, cs_n, convst_n, busy_n;
    logic [WORD_W-1:0] data_out, data_oe, w, oe, last_exp;
    int err_count = 0, checks = 0, seed;
    logic [RESULT_W-1:0] corner [4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
    apof_top i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .rd_n(rd_n), .cs_n(cs_n), .convst_n(convst_n),
        .polarity_select(polarity_select), .readback_mode(readback_mode),
        .sequencer_status_word(sequencer_status_word), .chan_addr(chan_addr), .diff_mode(diff_mode),
        .conv_done(conv_done), .raw_result(raw_result), .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe));
    apof_host i_host (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .cs_n(cs_n),
        .convst_n(convst_n));
    always #25 clk_sys = ~clk_sys;
    function automatic logic [WORD_W-1:0] exp_word(input logic [11:0] r, input logic [2:0] c, input logic d, p);
        return {p ? {~r[11], r[10:0]} : r, c, d};
    endfunction
    task automatic check(input string name, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic conv(input logic [11:0] r);
        int n;
        i_host.start();
        n = 0;
        while (busy_n !== 1'b0 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("busy low", WORD_W'(busy_n), 16'h0000);
        conv_done = 1'b1;
        @(negedge clk_sys);
        conv_done = 1'b0;
        @(negedge clk_sys);
        check("busy high", WORD_W'(busy_n), 16'h0001);
        i_host.rd_word(1'b0, w, oe);
        check("oe", oe, 16'hFFFF);
        last_exp = exp_word(r, chan_addr, diff_mode, polarity_select);
        check("word", w, last_exp);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end
    initial begin
        seed = $urandom(31309);
        repeat (12) @(negedge clk_sys);
        check("rst oe", data_oe, 16'h0000);
        check("rst busy", WORD_W'(busy_n), 16'h0001);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        for (int i = 0; i < 12; i++) begin
            polarity_select = i[0];
            chan_addr = 3'($urandom);
            diff_mode = 1'($urandom);
            raw_result = i < 8 ? corner[i / 2] : 12'($urandom);
            conv(raw_result);
        end
        // Result pulse while idle must leave the held word alone
        raw_result = ~raw_result;
        conv_done = 1'b1;
        @(negedge clk_sys);
        conv_done = 1'b0;
        i_host.rd_word(1'b0, w, oe);
        check("idle done word", w, last_exp);
        repeat (5) @(negedge clk_sys);
        // Clock enable low keeps the pins released
        ce = 1'b0;
        i_host.rd_word(1'b0, w, oe);
        check("ce oe", oe, 16'h0000);
        ce = 1'b1;
        repeat (5) @(negedge clk_sys);
        i_host.rd_word(1'b1, w, oe);
        check("cs high oe", oe, 16'h0000);
        readback_mode = 1'b1;
        sequencer_status_word = 7'($urandom);
        i_host.rd_word(1'b0, w, oe);
        check("rb oe", oe, 16'hE00F);
        check("rb word", w & 16'hE00F, {sequencer_status_word[6:4], 9'h000, sequencer_status_word[3:0]});
        repeat (5) @(negedge clk_sys);
        check("rb idle", data_oe & 16'h1FF0, 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
